// ===== verilog/fcpwm_regs.vh
// Register map, field positions and reset values of the PWM unit
//
// Function
// - Four 8-bit channels, two 16-bit, or one 16-bit plus two 8-bit.
// - Every channel owns a counter, a period value and a duty value.
// - Duty spans zero to full; left and center alignment both offered.
// - Writes while enabled wait in a buffer until rollover or disable.
// - Writes while disabled load buffer and active latch together.
// - Counter write clears counter and loads buffered period and duty.
// - Counters read back at any time without disturbing them.
// - Enabled channel owns its port pin; others stay general I/O.
// - Pairing 2 and 3: ch2 high byte, pin 2 out, ch3 clock select.
// - Pairing 0 and 1: ch0 high byte, pin 0 out, ch1 clock select.
// - Clocks A and B divide bus clock by two to field value.
// - Clock select bit picks A/B at 0, scaled S0/S1 at 1.
// - Changing clock select mid-waveform may give one odd pulse.
// - Polarity bits act in left-aligned mode only.
// - Polarity 0 starts low, rises on duty; polarity 1 the reverse.
// - Duty counts low time at polarity 0, high time at polarity 1.
// - Enable forces pin to output, direction bit left untouched.
// - Enable gates the selected clock into the channel.
// - Prescaler counter stops while all four channels are disabled.
// - Clock gating changes only on a clock edge, no partial pulses.
// - Waveform reaches pin at next cycle of the channel clock.
// - S0 is A over scale plus one, halved; S1 likewise from B.
// - Output changes state once counter passes duty (left) or reaches it (center).
// - Left period is channel clock times period plus one.
// - Center mode counts up and down, turning on period match.
`ifndef FCPWM_REGS_VH
`define FCPWM_REGS_VH
// Register indices; byte address is four times the index
`define FCPWM_IDX_CLK    7'h40
`define FCPWM_IDX_POL    7'h41
`define FCPWM_IDX_EN     7'h42
`define FCPWM_IDX_PRES   7'h43
`define FCPWM_IDX_SCAL0  7'h44
`define FCPWM_IDX_SCNT0  7'h45
`define FCPWM_IDX_SCAL1  7'h46
`define FCPWM_IDX_SCNT1  7'h47
`define FCPWM_IDX_CNT0   7'h48
`define FCPWM_IDX_PER0   7'h4c
`define FCPWM_IDX_DTY0   7'h50
`define FCPWM_IDX_CTL    7'h54
// Field positions in the clock register
`define FCPWM_PAIR_UP    7
`define FCPWM_PAIR_LO    6
`define FCPWM_DIVA_HI    5
`define FCPWM_DIVA_LO    3
`define FCPWM_DIVB_HI    2
`define FCPWM_DIVB_LO    0
// Field position in the control register
`define FCPWM_CENTER     3
// Reset values
`define FCPWM_RST_CLK    8'h00
`define FCPWM_RST_POL    8'h00
`define FCPWM_RST_EN     4'h0
`define FCPWM_RST_CTL    8'h00
`define FCPWM_RST_PER    8'hff
`define FCPWM_RST_DTY    8'hff
`define FCPWM_RST_SCAL   8'h00
`endif

// ===== verilog/fcpwm_unit.v
// Four-channel PWM unit with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "fcpwm_regs.vh"

module fcpwm_unit #(
  parameter NCH = 4
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // General-purpose port side
  input  wire [3:0]  gpioData,
  input  wire [3:0]  port_direction_bits,
  // Port pins
  output reg  [3:0]  pinOut,
  output wire [3:0]  pinOe
);

  // ==========================================================
  // Registers
  // ==========================================================
  reg  [7:0] clkReg_r;
  reg  [7:0] polReg_r;
  reg  [3:0] enReg_r;
  reg  [7:0] ctlReg_r;
  reg  [6:0] pres_r;
  reg  [7:0] scal0_r;
  reg  [7:0] scal1_r;
  reg  [7:0] scnt0_r;
  reg  [7:0] scnt1_r;
  reg        half0_r;
  reg        half1_r;
  reg  [7:0] cnt_r   [0:NCH-1];
  reg  [7:0] perB_r  [0:NCH-1];
  reg  [7:0] dtyB_r  [0:NCH-1];
  reg  [7:0] perA_r  [0:NCH-1];
  reg  [7:0] dtyA_r  [0:NCH-1];
  reg  [3:0] down_r;
  reg  [3:0] pwm_r;
  reg  [3:0] started_r;
  reg  [7:0] cnt_nxt  [0:NCH-1];
  reg  [7:0] perB_nxt [0:NCH-1];
  reg  [7:0] dtyB_nxt [0:NCH-1];
  reg  [7:0] perA_nxt [0:NCH-1];
  reg  [7:0] dtyA_nxt [0:NCH-1];
  reg  [3:0] down_nxt;
  reg  [3:0] pwm_nxt;
  reg  [3:0] started_nxt;

  // ==========================================================
  // Bus decode
  // ==========================================================
  wire [6:0] idx     = paddr[8:2];
  wire       mapped  = (idx >= `FCPWM_IDX_CLK) &&
                       (idx <= `FCPWM_IDX_CTL) &&
                       (paddr[31:9] == 23'h000000);
  wire       wrEn    = psel & penable & pwrite & mapped;
  wire       rdSetup = psel & ~penable;
  // Zero-wait slave: access phase always completes at once
  assign pready = penable;

  // ==========================================================
  // Configuration fields
  // ==========================================================
  wire [1:0] pairOn  = {clkReg_r[`FCPWM_PAIR_UP],
                        clkReg_r[`FCPWM_PAIR_LO]};
  wire [2:0] divA    = clkReg_r[`FCPWM_DIVA_HI:`FCPWM_DIVA_LO];
  wire [2:0] divB    = clkReg_r[`FCPWM_DIVB_HI:`FCPWM_DIVB_LO];
  wire [3:0] selBits = polReg_r[7:4];
  wire [3:0] polBits = polReg_r[3:0];
  wire       center  = ctlReg_r[`FCPWM_CENTER];
  wire       anyEn   = |enReg_r;
  // Slave channel of a pair gives up its pin and counter control
  wire [3:0] isSlave = {pairOn[1], 1'b0, pairOn[0], 1'b0};
  // Effective enable: a slave follows the enable of its lead
  wire [3:0] enEff   = {pairOn[1] ? enReg_r[2] : enReg_r[3],
                        enReg_r[2],
                        pairOn[0] ? enReg_r[0] : enReg_r[1],
                        enReg_r[0]};

  // ==========================================================
  // Prescaler and scalers
  // ==========================================================
  // Divide-by-two-to-the-n tick taken from the prescaler
  wire [6:0] maskA = (7'h01 << divA) - 7'h01;
  wire [6:0] maskB = (7'h01 << divB) - 7'h01;
  wire tickA = anyEn & ((pres_r & maskA) == maskA);
  wire tickB = anyEn & ((pres_r & maskB) == maskB);
  // Scaled tick every second reload of the down-counter
  wire s0Tick = tickA & (scnt0_r == 8'h00) & half0_r;
  wire s1Tick = tickB & (scnt1_r == 8'h00) & half1_r;
  // Prescaler runs only while a channel is enabled
  always @(posedge clock) begin
    if (reset) begin
      pres_r <= 7'h00;
    end else if (anyEn) begin
      pres_r <= pres_r + 7'h01;
    end
  end
  // Scale counters reload on a scale write or on reaching zero
  always @(posedge clock) begin
    if (reset) begin
      scnt0_r <= 8'h00;
      scnt1_r <= 8'h00;
      half0_r <= 1'b0;
      half1_r <= 1'b0;
    end else begin
      if (wrEn && idx == `FCPWM_IDX_SCAL0) begin
        scnt0_r <= pwdata[7:0];
      end else if (tickA) begin
        if (scnt0_r == 8'h00) begin
          scnt0_r <= scal0_r;
          half0_r <= ~half0_r;
        end else begin
          scnt0_r <= scnt0_r - 8'h01;
        end
      end
      if (wrEn && idx == `FCPWM_IDX_SCAL1) begin
        scnt1_r <= pwdata[7:0];
      end else if (tickB) begin
        if (scnt1_r == 8'h00) begin
          scnt1_r <= scal1_r;
          half1_r <= ~half1_r;
        end else begin
          scnt1_r <= scnt1_r - 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Channel clock gating
  // ==========================================================
  // Each channel sees its selected tick only while enabled; a pair
  // uses the select bit of its low-byte channel. Ticks are whole
  // clock-cycle pulses and the enable is a register, so gating
  // changes only on an edge. Switching the select mid-period may
  // shorten or stretch one pulse; that is accepted.
  wire [3:0] srcSel = {selBits[3], pairOn[1] ? selBits[3] : selBits[2],
                       selBits[1], pairOn[0] ? selBits[1] : selBits[0]};
  wire [3:0] chTick;
  assign chTick[0] = enEff[0] & (srcSel[0] ? s0Tick : tickA);
  assign chTick[1] = enEff[1] & (srcSel[1] ? s0Tick : tickA);
  assign chTick[2] = enEff[2] & (srcSel[2] ? s1Tick : tickB);
  assign chTick[3] = enEff[3] & (srcSel[3] ? s1Tick : tickB);

  // ==========================================================
  // Channel engines
  // ==========================================================
  integer    i;
  reg        wide;
  reg        cntWr;
  reg        roll;
  reg [15:0] c;
  reg [15:0] p;
  reg [15:0] d;
  reg        dn;
  reg        lvl;
  reg  [3:0] rollV;
  // Buffered values: a write always lands in the buffer
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      perB_nxt[i] = perB_r[i];
      dtyB_nxt[i] = dtyB_r[i];
      if (wrEn && idx == `FCPWM_IDX_PER0 + i) begin
        perB_nxt[i] = pwdata[7:0];
      end
      if (wrEn && idx == `FCPWM_IDX_DTY0 + i) begin
        dtyB_nxt[i] = pwdata[7:0];
      end
    end
  end
  // Counter, active latches and output level of each lead channel
  always @* begin
    wide  = 1'b0;
    cntWr = 1'b0;
    roll  = 1'b0;
    c     = 16'h0000;
    p     = 16'h0000;
    d     = 16'h0000;
    dn    = 1'b0;
    lvl   = 1'b0;
    rollV = 4'h0;
    down_nxt    = down_r;
    pwm_nxt     = pwm_r;
    started_nxt = started_r & enEff;
    for (i = 0; i < NCH; i = i + 1) begin
      cnt_nxt[i]  = cnt_r[i];
      perA_nxt[i] = perA_r[i];
      dtyA_nxt[i] = dtyA_r[i];
    end
    for (i = 0; i < NCH; i = i + 1) begin
      if (!isSlave[i]) begin
        // Pair view: even channel is the high byte
        wide  = (i % 2 == 0) && pairOn[i/2];
        cntWr = wrEn && (idx == `FCPWM_IDX_CNT0 + i);
        if (wide) begin
          c = {cnt_r[i], cnt_r[i+1]};
          p = {perA_r[i], perA_r[i+1]};
          d = {dtyA_r[i], dtyA_r[i+1]};
          cntWr = cntWr || (wrEn && idx == `FCPWM_IDX_CNT0 + i + 1);
        end else begin
          c = {8'h00, cnt_r[i]};
          p = {8'h00, perA_r[i]};
          d = {8'h00, dtyA_r[i]};
        end
        dn   = down_r[i];
        roll = 1'b0;
        if (cntWr) begin
          // Clear the count and take pending values now
          c    = 16'h0000;
          dn   = 1'b0;
          roll = 1'b1;
        end else if (chTick[i]) begin
          if (!center) begin
            if (c == p) begin
              c    = 16'h0000;
              roll = 1'b1;
            end else begin
              c = c + 16'h0001;
            end
          end else begin
            // Up/down count, turning at period and at zero
            if (!dn && c >= p) begin
              dn = (p != 16'h0000);
              c  = (p != 16'h0000) ? c - 16'h0001 : 16'h0000;
            end else if (dn && c == 16'h0000) begin
              dn   = 1'b0;
              c    = 16'h0001;
              roll = 1'b1;
            end else if (dn) begin
              c = c - 16'h0001;
            end else begin
              c = c + 16'h0001;
            end
          end
        end
        // Output: left mode starts from polarity, flips past duty match; center flips at match
        if (center) begin
          lvl = (c >= d);
        end else begin
          lvl = polBits[i] ^ (c > d);
        end
        if (chTick[i] || cntWr) begin
          pwm_nxt[i] = lvl;
        end
        if (chTick[i]) begin
          started_nxt[i] = 1'b1;
        end
        down_nxt[i] = dn;
        rollV[i]    = roll;
        if (wide) begin
          cnt_nxt[i]   = c[15:8];
          cnt_nxt[i+1] = c[7:0];
        end else begin
          cnt_nxt[i] = c[7:0];
        end
      end
    end
    // Active latch loads: disabled follows buffer, enabled waits
    for (i = 0; i < NCH; i = i + 1) begin
      if (!enEff[i]) begin
        perA_nxt[i] = perB_nxt[i];
        dtyA_nxt[i] = dtyB_nxt[i];
      end
    end
    for (i = 0; i < NCH; i = i + 1) begin
      if (!isSlave[i] && enEff[i] && rollV[i]) begin
        perA_nxt[i] = perB_nxt[i];
        dtyA_nxt[i] = dtyB_nxt[i];
        if ((i % 2 == 0) && pairOn[i/2]) begin
          perA_nxt[i+1] = perB_nxt[i+1];
          dtyA_nxt[i+1] = dtyB_nxt[i+1];
        end
      end
    end
  end

  // Channel state registers
  always @(posedge clock) begin
    if (reset) begin
      for (i = 0; i < NCH; i = i + 1) begin
        cnt_r[i]  <= 8'h00;
        perB_r[i] <= `FCPWM_RST_PER;
        dtyB_r[i] <= `FCPWM_RST_DTY;
        perA_r[i] <= `FCPWM_RST_PER;
        dtyA_r[i] <= `FCPWM_RST_DTY;
      end
      down_r    <= 4'h0;
      pwm_r     <= 4'h0;
      started_r <= 4'h0;
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        cnt_r[i]  <= cnt_nxt[i];
        perB_r[i] <= perB_nxt[i];
        dtyB_r[i] <= dtyB_nxt[i];
        perA_r[i] <= perA_nxt[i];
        dtyA_r[i] <= dtyA_nxt[i];
      end
      down_r    <= down_nxt;
      pwm_r     <= pwm_nxt;
      started_r <= started_nxt;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  always @(posedge clock) begin
    if (reset) begin
      clkReg_r <= `FCPWM_RST_CLK;
      polReg_r <= `FCPWM_RST_POL;
      enReg_r  <= `FCPWM_RST_EN;
      ctlReg_r <= `FCPWM_RST_CTL;
      scal0_r  <= `FCPWM_RST_SCAL;
      scal1_r  <= `FCPWM_RST_SCAL;
    end else if (wrEn) begin
      case (idx)
        `FCPWM_IDX_CLK:   clkReg_r <= pwdata[7:0];
        `FCPWM_IDX_POL:   polReg_r <= pwdata[7:0];
        `FCPWM_IDX_EN:    enReg_r  <= pwdata[3:0];
        `FCPWM_IDX_CTL:   ctlReg_r <= pwdata[7:0];
        `FCPWM_IDX_SCAL0: scal0_r  <= pwdata[7:0];
        `FCPWM_IDX_SCAL1: scal1_r  <= pwdata[7:0];
        default:          ;
      endcase
    end
  end

  // ==========================================================
  // Read path, captured in the setup cycle
  // ==========================================================
  reg [7:0] rdVal;
  always @* begin
    rdVal = 8'h00;
    case (idx)
      `FCPWM_IDX_CLK:   rdVal = clkReg_r;
      `FCPWM_IDX_POL:   rdVal = polReg_r;
      `FCPWM_IDX_EN:    rdVal = {4'h0, enReg_r};
      `FCPWM_IDX_PRES:  rdVal = {1'b0, pres_r};
      `FCPWM_IDX_SCAL0: rdVal = scal0_r;
      `FCPWM_IDX_SCNT0: rdVal = scnt0_r;
      `FCPWM_IDX_SCAL1: rdVal = scal1_r;
      `FCPWM_IDX_SCNT1: rdVal = scnt1_r;
      `FCPWM_IDX_CTL:   rdVal = ctlReg_r;
      default: begin
        if (idx >= `FCPWM_IDX_CNT0 && idx < `FCPWM_IDX_PER0) begin
          rdVal = cnt_r[idx[1:0]];
        end else if (idx >= `FCPWM_IDX_PER0 &&
                     idx < `FCPWM_IDX_DTY0) begin
          rdVal = perB_r[idx[1:0]];
        end else if (idx >= `FCPWM_IDX_DTY0 &&
                     idx < `FCPWM_IDX_CTL) begin
          rdVal = dtyB_r[idx[1:0]];
        end
      end
    endcase
  end

  // Read data and error response registered for the access phase
  always @(posedge clock) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rdSetup) begin
      prdata  <= (pwrite | ~mapped) ? 32'h00000000 : {24'h000000, rdVal};
      pslverr <= ~mapped;
    end
  end

  // ==========================================================
  // Pin takeover
  // ==========================================================
  // Enabled lead channels force the pin to output
  wire [3:0] owns = enEff & ~isSlave;
  assign pinOe = owns | port_direction_bits;

  // Pin level registered; waveform only after first channel tick
  always @(posedge clock) begin
    if (reset) begin
      pinOut <= 4'h0;
    end else begin
      pinOut <= (owns & started_nxt & pwm_nxt) |
                (~(owns & started_nxt) & gpioData);
    end
  end

endmodule // fcpwm_unit
`default_nettype wire

// ===== testbench/fcpwm_pin_load.sv
// Load model of the port pins seen by the PWM unit
`timescale 1ns/10ps
`default_nettype none
module fcpwm_pin_load (
  // Unit side
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  // Pad side
  output logic      [3:0] padLevel
);
  // Driven pins show the unit level, released pins float to the pull-up
  assign padLevel = (pinOut & pinOe) | ~pinOe;
endmodule // fcpwm_pin_load
`default_nettype wire

// ===== testbench/fcpwm_unit_chk.sv
// Port checker for the PWM unit
`timescale 1ns/10ps
`default_nettype none
module fcpwm_unit_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Port side
  input wire logic [3:0]  gpioData,
  input wire logic [3:0]  port_direction_bits,
  input wire logic [3:0]  pinOut,
  input wire logic [3:0]  pinOe
);
  logic [3:0] enS_r;
  logic [1:0] pairS_r;
  logic [3:0] owned;
  logic [6:0] idx;
  logic       acc;
  logic       bad;
  // Access decode; slave channels of a pair never own a pin
  assign idx = paddr[8:2];
  assign acc = psel & penable;
  assign bad = (idx < 7'h40) | (idx > 7'h54) | (paddr[31:9] != 23'h0);
  assign owned = enS_r & ~{pairS_r[1], 1'b0, pairS_r[0], 1'b0};
  // Shadow of enable and pairing bits
  always_ff @(posedge clock) begin
    if (reset) begin
      enS_r <= 4'h0;
      pairS_r <= 2'h0;
    end else begin
      if (acc & pwrite & (idx == 7'h42))
        enS_r <= pwdata[3:0];
      if (acc & pwrite & (idx == 7'h40))
        pairS_r <= pwdata[7:6];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================================
  // Assertions
  AST_OE_MAP:
    assert property (pinOe == (port_direction_bits | owned))
    else $error("pin enables differ from ownership");
  AST_PAIR_LO:
    assert property (pairS_r[0] |-> pinOe[1] == port_direction_bits[1])
    else $error("paired channel 1 drives its pin");
  AST_PAIR_UP:
    assert property (pairS_r[1] |-> pinOe[3] == port_direction_bits[3])
    else $error("paired channel 3 drives its pin");
  AST_EN_READ:
    assert property (acc & !pwrite & (idx == 7'h42)
      |-> prdata[7:0] == {4'h0, enS_r}) else $error("enable readback");
  AST_GPIO_PASS:
    assert property (!$past(reset) |-> ((pinOut ^ $past(gpioData))
      & ~owned & ~$past(owned)) == 4'h0) else $error("port data lost");
  AST_OE_RELEASE:
    assert property (acc & pwrite & (idx == 7'h42) & (pwdata[3:0] == 4'h0)
      |=> pinOe == port_direction_bits) else $error("pins not released");
  AST_READY:
    assert property (psel & !penable |=> pready)
    else $error("no ready in access phase");
  AST_ERR:
    assert property (acc & bad |-> pslverr & (pwrite | prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_NO_ERR:
    assert property (acc & !bad |-> !pslverr)
    else $error("mapped access refused");
  // Main scenarios
  COV_PAIR: cover property (pairS_r == 2'h3 && owned[0]);
  COV_REFUSE: cover property (acc && pslverr);
  COV_WAVE: cover property (owned[0] ##1 $rose(pinOut[0]));
endmodule // fcpwm_unit_chk
`default_nettype wire

// ===== testbench/fcpwm_unit_bench.sv
// Self-checking bench of the PWM unit
`timescale 1ns/10ps
`default_nettype none
module fcpwm_unit_bench;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  gpioData, port_direction_bits, pinOut, pinOe, padLevel;
  int          bad_count, cmp_count;
  // ==========================================================
  // Unit and pin load
  fcpwm_unit dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gpioData(gpioData), .port_direction_bits(port_direction_bits),
    .pinOut(pinOut), .pinOe(pinOe));
  fcpwm_pin_load load (.pinOut(pinOut), .pinOe(pinOe),
    .padLevel(padLevel));
  // Clock of 25 ns
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ==========================================================
  // Shared tasks
  task automatic final_report;
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [6:0] ix,
    input logic [7:0] d, output logic [31:0] r, output logic er);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {23'h0, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [6:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ix, d, r, e);
  endtask
  task automatic rd(input logic [6:0] ix, output logic [31:0] r);
    logic e;
    apb(1'b0, ix, 8'h00, r, e);
  endtask
  // Count high samples and rising edges on a pad
  task automatic meas(input int len, b, output int hi, up);
    logic p;
    hi = 0;
    up = 0;
    p = padLevel[b];
    repeat (len) begin
      @(negedge clock);
      hi += padLevel[b];
      up += padLevel[b] & ~p;
      p = padLevel[b];
    end
  endtask
  // Program channel 0 while stopped, restart it and measure
  task automatic run(input logic [7:0] ck, pl, sc, per, dt,
    input int len, eh, eu);
    int hi, up;
    wr(7'h42, 8'h00);
    wr(7'h40, ck);
    wr(7'h41, pl);
    wr(7'h44, sc);
    wr(7'h4c, per);
    wr(7'h50, dt);
    wr(7'h48, 8'h00);
    wr(7'h42, 8'h01);
    repeat (len) @(posedge clock);
    meas(len, 0, hi, up);
    chk("high time", eh, hi);
    chk("rises", eu, up);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] r, a;
    logic e;
    rd(7'h41, r); chk("select reg", 32'h0, r);
    rd(7'h4c, r); chk("period reg", 32'hff, r);
    rd(7'h50, r); chk("duty reg", 32'hff, r);
    wr(7'h42, 8'hff);
    rd(7'h42, r); chk("enable reg", 32'h0f, r);
    wr(7'h42, 8'h00);
    wr(7'h48, 8'h00);
    rd(7'h48, r); chk("stopped counter", 32'h0, r);
    apb(1'b0, 7'h10, 8'h00, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    rd(7'h43, a);
    wr(7'h43, 8'h55);
    rd(7'h43, r); chk("idle prescaler", a, r);
  endtask
  // Center alignment ignores polarity; count runs up and back down
  task automatic t_center;
    wr(7'h42, 8'h00);
    wr(7'h54, 8'h08);
    run(8'h00, 8'h01, 8'h00, 8'h04, 8'h01, 16, 14, 2);
    wr(7'h42, 8'h00);
    wr(7'h54, 8'h00);
  endtask
  task automatic t_wave;
    run(8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8, 6, 2);
    run(8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8, 2, 2);
    run(8'h00, 8'h00, 8'h00, 8'h03, 8'hff, 8, 0, 0);
    run(8'h00, 8'h01, 8'h00, 8'h03, 8'hff, 8, 8, 0);
    run(8'h00, 8'h00, 8'h00, 8'h07, 8'h02, 16, 10, 2);
    run(8'h10, 8'h00, 8'h00, 8'h03, 8'h01, 64, 32, 4);
    run(8'h00, 8'h10, 8'h01, 8'h03, 8'h01, 64, 32, 4);
  endtask
  task automatic t_buffer;
    logic [31:0] a, b;
    int hi, up;
    run(8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8, 6, 2);
    rd(7'h48, a); chk("count range", 32'h1, {31'h0, a <= 3});
    rd(7'h43, a);
    rd(7'h43, b); chk("prescaler runs", 32'h1, {31'h0, a != b});
    wr(7'h4c, 8'h07);
    wr(7'h50, 8'h02);
    rd(7'h4c, a); chk("period buffer", 32'h07, a);
    repeat (16) @(posedge clock);
    meas(16, 0, hi, up);
    chk("rollover load", 32'd10, hi);
  endtask
  task automatic t_pair;
    int hi, up;
    wr(7'h42, 8'h00);
    wr(7'h40, 8'hc0);
    wr(7'h41, 8'h00);
    wr(7'h4c, 8'h00);
    wr(7'h4d, 8'h03);
    wr(7'h50, 8'h00);
    wr(7'h51, 8'h01);
    wr(7'h4e, 8'h00);
    wr(7'h4f, 8'h03);
    wr(7'h52, 8'h00);
    wr(7'h53, 8'h01);
    wr(7'h4a, 8'h00);
    wr(7'h48, 8'h00);
    wr(7'h42, 8'h0f);
    @(posedge clock);
    chk("pair enables", 32'hd, {28'h0, pinOe});
    repeat (8) @(posedge clock);
    meas(8, 0, hi, up);
    chk("wide high time", 32'd4, hi);
    meas(8, 2, hi, up);
    chk("upper wide high time", 32'd4, hi);
    wr(7'h42, 8'h00);
  endtask
  // Main sequence
  initial begin
    bad_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    gpioData = 4'ha;
    port_direction_bits = 4'h8;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_wave();
    t_buffer();
    t_center();
    t_pair();
    final_report();
  end
endmodule // fcpwm_unit_bench
bind fcpwm_unit fcpwm_unit_chk u_chk (.clock(clock), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .gpioData(gpioData), .port_direction_bits(port_direction_bits),
  .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire
